// ### testbench/host_model.sv
// Behavioural host that drives the serial command port of the rheostat block
module host_model (
  output logic     serial_clk, // Link clock, idle low outside frames except while noise runs
  output logic     serial_in,  // Serial data to the device
  output logic     cs_n,       // Chip select, active low
  input  wire logic sdo_line   // Resolved open-drain data line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    serial_clk = 1'b0;
    serial_in  = 1'b1;
    cs_n       = 1'b1;
  end

  // One 24-bit frame; rx holds the line before the first edge and after each
  task automatic send(input logic [23:0] wd, output logic [24:0] rx);
    #13 cs_n = 1'b0;
    #80 rx = {24'h000000, sdo_line};
    for (int k = 23; k >= 0; k--) begin
      serial_in = wd[k];
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
      rx = {rx[23:0], sdo_line};
    end
    #80 cs_n = 1'b1;
    serial_in = ~serial_in;
    #160;
  endtask : send

  // Clock and data activity while deselected, commanded by the bench
  task automatic noise();
    #13;
    repeat (6) begin
      serial_in = ~serial_in;
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
    end
  endtask : noise
endmodule : host_model

// ### testbench/testbench.sv
// Self-checking bench with a behavioural model of the rheostat block
`define CHECK(g, e) begin \
  samples_checked++; \
  if (24'(g) !== 24'(e)) begin \
    miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 24'(g), 24'(e)); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rheostat_pkg::*;

  logic       clk = 1'b0;
  logic       rstn;
  logic       wp_n;
  logic       hw_preset_n;
  wire        serial_clk;
  wire        serial_in;
  wire        cs_n;
  wire        sdo_line;
  logic       serial_out;
  logic       serial_out_oe_n;
  logic       ready;
  logic       ready_oe_n;
  logic [9:0] wiper1_setting;
  logic [9:0] wiper2_setting;
  int         miscompares;
  int         samples_checked;
  int         low_cnt = 0;
  int         w[2];
  int         nv[16];
  logic [23:0] exp_rx;
  bit         rb_mode;
  bit         prev_valid;

  // Pull-up on the open-drain data line
  assign sdo_line = serial_out_oe_n ? 1'b1 : serial_out;

  always #20 clk = ~clk;

  // Busy cycles seen on the ready line, sampled away from the launching edge
  always @(negedge clk) low_cnt += (ready_oe_n === 1'b0);

  rheostat_serial_control dut_u (
    .clk(clk), .rstn(rstn), .serial_clk(serial_clk), .serial_in(serial_in), .cs_n(cs_n),
    .wp_n(wp_n), .hw_preset_n(hw_preset_n), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .ready(ready), .ready_oe_n(ready_oe_n),
    .wiper1_setting(wiper1_setting), .wiper2_setting(wiper2_setting)
  );

  host_model host_u (
    .serial_clk(serial_clk), .serial_in(serial_in), .cs_n(cs_n), .sdo_line(sdo_line)
  );

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Reference behaviour of one executed word
  task automatic model_exec(input logic [23:0] wd, output bit long_op);
    int op, ad, a, d;
    bit prot;
    op = wd[23:20];
    ad = wd[19:16];
    a = wd[16];
    d = wd[15:0];
    prot = !wp_n;
    long_op = 0;
    exp_rx = wd;
    rb_mode = 0;
    case (op)
      0: ;
      1: w[a] = nv[a] % 1024;
      2: if (!prot) begin nv[a] = w[a]; long_op = 1; end
      3: if (!prot) begin nv[ad] = d; long_op = 1; end
      8: begin for (int i = 0; i < 2; i++) w[i] = nv[i] % 1024; long_op = 1; end
      9: begin exp_rx = {wd[23:16], 16'(nv[ad])}; rb_mode = 1; long_op = 1; end
      10: begin exp_rx = {wd[23:16], 16'(w[a])}; rb_mode = 1; long_op = 1; end
      11: if (!prot) w[a] = d % 1024;
      default: if (!prot) for (int i = 0; i < 2; i++) if (op % 2 == 1 || i == a)
        case (op / 2)
          2: w[i] = w[i] / 2;
          3: w[i] = (w[i] > 0) ? w[i] - 1 : 0;
          6: w[i] = (w[i] >= 512) ? 1023 : w[i] * 2 + 1;
          default: w[i] = (w[i] < 1023) ? w[i] + 1 : 1023;
        endcase
    endcase
  endtask : model_exec

  task automatic check_after(input bit lg, input int base);
    repeat (1300) @(posedge clk);
    `CHECK(low_cnt - base, lg ? LONG_OP_CYCLES : 0)
    `CHECK(ready, 1'b0)
    `CHECK(wiper1_setting, w[0])
    `CHECK(wiper2_setting, w[1])
  endtask : check_after

  task automatic frame(input logic [23:0] wd);
    logic [24:0] rx;
    bit lg;
    int base;
    base = low_cnt;
    host_u.send(wd, rx);
    if (prev_valid)
      `CHECK(rx[23:0], exp_rx)
    prev_valid = 1;
    model_exec(wd, lg);
    check_after(lg, base);
  endtask : frame

  initial begin
    int op, ad;
    rstn = 1'b0;
    wp_n = 1'b1;
    hw_preset_n = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    prev_valid = 0;
    foreach (nv[i]) nv[i] = (i < 2) ? 512 : 0;
    w[0] = 512;
    w[1] = 512;
    void'($urandom(67461));
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    `CHECK(wiper1_setting, WIPER_RESET)
    `CHECK(wiper2_setting, WIPER_RESET)
    frame({8'hB0, 16'($urandom)});
    // Preset under protection: low level must do nothing, the rise reloads
    @(negedge clk) wp_n = 1'b0;
    @(negedge clk) hw_preset_n = 1'b0;
    repeat (50) @(posedge clk);
    `CHECK(wiper1_setting, w[0])
    @(negedge clk) hw_preset_n = 1'b1;
    for (int i = 0; i < 2; i++) w[i] = nv[i] % 1024;
    check_after(1, low_cnt);
    frame(24'h000000);
    @(negedge clk) wp_n = 1'b1;
    for (int i = 0; i < 40; i++) begin
      op = (i < 16) ? i : (i >= 22 && i < 31) ? (i * 3) % 16 : (i == 31) ? 0 : $urandom % 16;
      if (i == 22) @(negedge clk) wp_n = 1'b0;
      ad = (op == 3 || op == 9) ? $urandom % 16 : $urandom % 2;
      frame({4'(op), 4'(ad), 16'($urandom)});
      if (i == 31) @(negedge clk) wp_n = 1'b1;
      if (i == 20) host_u.noise();
    end
    frame(24'h000000);
    wrap_up();
  end

  // About 43 frames of 56 us each and the preset check, plus a third for margin
  initial begin
    #3_400_000;
    miscompares++;
    wrap_up();
  end
endmodule : testbench

// ### verilog/rheostat_pkg.sv
// Package of constants and types for the rheostat serial control block
package rheostat_pkg;
  localparam int         WORD_BITS        = 24;
  localparam int         WIPER_BITS       = 10;
  localparam int         NV_BITS          = 16;
  localparam int         NV_WORDS         = 16;
  localparam int         CNT_BITS         = 5;
  // Command word fields
  localparam int         OP_MSB           = 23;
  localparam int         OP_LSB           = 20;
  localparam int         ADDR_MSB         = 19;
  localparam int         ADDR_LSB         = 16;
  localparam int         DATA_MSB         = 15;
  // Reset values and wiper constants
  localparam logic [9:0]  WIPER_RESET     = 10'h200;
  localparam logic [15:0] NV_WIPER_RESET  = 16'h0200;
  localparam logic [15:0] NV_OTHER_RESET  = 16'h0000;
  localparam logic [9:0]  WIPER_ZERO      = 10'h000;
  localparam logic [9:0]  WIPER_FULL      = 10'h3FF;
  localparam logic [9:0]  WIPER_ONE       = 10'h001;
  // Timing
  localparam int         CLK_PERIOD_NS    = 40;
  localparam int         LONG_OP_TIME_NS  = 50000;
  localparam int         LONG_OP_CYCLES   = (LONG_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         BUSY_BITS        = 11;
  localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h18;
  localparam logic [CNT_BITS-1:0] CNT_LAST = 5'h17;

  typedef enum logic [3:0] {
    OP_NOP       = 4'h0, OP_RECALL    = 4'h1, OP_SAVE      = 4'h2, OP_NV_WRITE  = 4'h3,
    OP_DEC6      = 4'h4, OP_DEC6_ALL  = 4'h5, OP_DEC1      = 4'h6, OP_DEC1_ALL  = 4'h7,
    OP_RECALL_ALL = 4'h8, OP_NV_READ  = 4'h9, OP_WIPER_READ = 4'hA, OP_WIPER_WRITE = 4'hB,
    OP_INC6      = 4'hC, OP_INC6_ALL  = 4'hD, OP_INC1      = 4'hE, OP_INC1_ALL  = 4'hF
  } command_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } ctrl_state_t;
endpackage : rheostat_pkg

// ### verilog/rheostat_serial_control.sv
// Serial command port, wiper registers and nonvolatile store of a dual rheostat
// Summary of operation
// RULE1: Capture serial_in on each rising serial clock
// RULE2: First received bit is word MSB
// RULE3: Execute shifted word when chip select rises
// RULE4: Open-drain ready marks long command completion
// RULE5: Write protect blocks all altering commands
// RULE6: Preset and recalls still work under protect
// RULE7: Host sends NOP before releasing write protect
// RULE8: Preset reloads wipers from nonvolatile store
// RULE9: Preset acts on its rising edge only
// RULE10: Nonvolatile wiper default is midscale 512
// RULE11: Address 0 is channel one, 1 two
// RULE12: Word is opcode, address, sixteen data bits
// RULE13: Serial out echoes input 24 clocks later
// RULE14: Code 8 recalls all, code 1 one
// RULE15: Chip select high freezes the serial logic; the bit counter is cleared rather than frozen
// RULE16: Ready low while long operation runs
module rheostat_serial_control (
  input  wire logic                             clk,            // System clock, 25 MHz
  input  wire logic                             rstn,           // Asynchronous reset, active low
  input  wire logic                             serial_clk,     // Link clock from host
  input  wire logic                             serial_in,      // Serial data in
  input  wire logic                             cs_n,           // Chip select, active low
  input  wire logic                             wp_n,           // Write protect, active low
  input  wire logic                             hw_preset_n,    // Hardware preset, active low
  output logic                                  serial_out,     // Open-drain data, always low
  output logic                                  serial_out_oe_n,// Low while pulling data low
  output logic                                  ready,          // Open-drain ready, always low
  output logic                                  ready_oe_n,     // Low while ready is pulled low
  output logic [rheostat_pkg::WIPER_BITS-1:0]   wiper1_setting, // Channel one wiper
  output logic [rheostat_pkg::WIPER_BITS-1:0]   wiper2_setting  // Channel two wiper
);
  import rheostat_pkg::*;

  logic [1:0]                rst_sync_reg;
  logic                      rst_n;
  logic [WORD_BITS-1:0]      shift_reg;
  logic [CNT_BITS-1:0]       bit_cnt_reg;
  logic                      out_reg;
  logic                      link_clr_n;
  logic [2:0]                cs_sync_reg;
  logic [1:0]                wp_sync_reg;
  logic [2:0]                pr_sync_reg;
  logic                      cs_rise;
  logic                      pr_rise;
  logic                      protect;
  logic [WIPER_BITS-1:0]     wiper_reg [2];
  logic [NV_BITS-1:0]        nv_reg [NV_WORDS];
  logic [WORD_BITS-1:0]      rb_word_reg;
  logic                      rb_mode_reg;
  ctrl_state_t               state_reg;
  logic [BUSY_BITS-1:0]      busy_cnt_reg;
  logic [BUSY_BITS-1:0]      busy_age_reg;
  logic                      exec;
  logic                      long_start;
  command_t                  op;
  logic [3:0]                addr;
  logic                      sel;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Link domain: shift register runs only while selected
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (!cs_n) begin                                          // [RULE15]
      shift_reg <= {shift_reg[WORD_BITS-2:0], serial_in};              // [RULE1] [RULE2]
    end
  end

  // Bit counter cleared by a deselected chip
  assign link_clr_n = rst_n & ~cs_n;
  always_ff @(posedge serial_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      bit_cnt_reg <= '0;
    end else if (bit_cnt_reg != 5'h1F) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // Daisy chain echo or readback word; readback data is static during the frame
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b1;
    end else if (!cs_n) begin
      if (rb_mode_reg) begin
        out_reg <= (bit_cnt_reg < CNT_FULL) ? rb_word_reg[CNT_LAST - bit_cnt_reg] : 1'b1;
      end else begin
        out_reg <= shift_reg[WORD_BITS-1];                             // [RULE13]
      end
    end
  end
  assign serial_out      = 1'b0;
  assign serial_out_oe_n = out_reg;

  // Pin synchronisers and edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_reg <= 3'h7;
      wp_sync_reg <= 2'h3;
      pr_sync_reg <= 3'h7;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
      wp_sync_reg <= {wp_sync_reg[0], wp_n};
      pr_sync_reg <= {pr_sync_reg[1:0], hw_preset_n};
    end
  end
  assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];                   // [RULE3]
  assign pr_rise = pr_sync_reg[1] & ~pr_sync_reg[2];                   // [RULE9]
  assign protect = ~wp_sync_reg[1];

  // Word is frozen once chip select is high
  assign exec = cs_rise && (state_reg == ST_IDLE);                     // [RULE16]
  assign op   = command_t'(shift_reg[OP_MSB:OP_LSB]);                  // [RULE12]
  assign addr = shift_reg[ADDR_MSB:ADDR_LSB];
  assign sel  = addr[0];                                               // [RULE11]
  assign long_start = pr_rise || (exec && (op == OP_RECALL_ALL || op == OP_NV_READ ||
                      op == OP_WIPER_READ || ((op == OP_SAVE || op == OP_NV_WRITE) && !protect)));

  function automatic logic [WIPER_BITS-1:0] step(input command_t c,
                                                 input logic [WIPER_BITS-1:0] w);
    logic [WIPER_BITS-1:0] r;
    r = w;
    case (c)
      OP_DEC6, OP_DEC6_ALL: r = w >> 1;
      OP_DEC1, OP_DEC1_ALL: r = (w == WIPER_ZERO) ? w : w - WIPER_ONE;
      OP_INC6, OP_INC6_ALL: r = w[WIPER_BITS-1] ? WIPER_FULL : {w[WIPER_BITS-2:0], 1'b1};
      OP_INC1, OP_INC1_ALL: r = (w == WIPER_FULL) ? w : w + WIPER_ONE;
      default:              r = w;
    endcase
    return r;
  endfunction : step

  // Wiper setting registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wiper_reg[0] <= WIPER_RESET;                                     // [RULE10]
      wiper_reg[1] <= WIPER_RESET;
    end else if (pr_rise) begin
      wiper_reg[0] <= nv_reg[0][WIPER_BITS-1:0];                       // [RULE8] [RULE6]
      wiper_reg[1] <= nv_reg[1][WIPER_BITS-1:0];
    end else if (exec) begin
      case (op)
        OP_RECALL_ALL: begin                                           // [RULE14] [RULE6]
          wiper_reg[0] <= nv_reg[0][WIPER_BITS-1:0];
          wiper_reg[1] <= nv_reg[1][WIPER_BITS-1:0];
        end
        OP_RECALL: wiper_reg[sel] <= nv_reg[{3'h0, sel}][WIPER_BITS-1:0]; // [RULE14]
        OP_WIPER_WRITE: begin
          if (!protect) begin                                          // [RULE5]
            wiper_reg[sel] <= shift_reg[WIPER_BITS-1:0];               // [RULE11]
          end
        end
        OP_DEC6, OP_DEC1, OP_INC6, OP_INC1: begin
          if (!protect) begin                                          // [RULE5]
            wiper_reg[sel] <= step(op, wiper_reg[sel]);
          end
        end
        OP_DEC6_ALL, OP_DEC1_ALL, OP_INC6_ALL, OP_INC1_ALL: begin
          if (!protect) begin                                          // [RULE5]
            wiper_reg[0] <= step(op, wiper_reg[0]);
            wiper_reg[1] <= step(op, wiper_reg[1]);
          end
        end
        default: ;
      endcase
    end
  end
  assign wiper1_setting = wiper_reg[0];
  assign wiper2_setting = wiper_reg[1];

  // Nonvolatile store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NV_WORDS; i++) begin
        nv_reg[i] <= (i < 2) ? NV_WIPER_RESET : NV_OTHER_RESET;       // [RULE10]
      end
    end else if (exec && !protect) begin                               // [RULE5]
      if (op == OP_SAVE) begin
        nv_reg[{3'h0, sel}] <= {6'h00, wiper_reg[sel]};
      end else if (op == OP_NV_WRITE) begin
        nv_reg[addr] <= shift_reg[DATA_MSB:0];                         // [RULE12]
      end
    end
  end

  // Readback word, changed only between frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_word_reg <= '0;
      rb_mode_reg <= 1'b0;
    end else if (exec) begin
      rb_mode_reg <= (op == OP_NV_READ) || (op == OP_WIPER_READ);
      if (op == OP_NV_READ) begin
        rb_word_reg <= {shift_reg[OP_MSB:ADDR_LSB], nv_reg[addr]};
      end else if (op == OP_WIPER_READ) begin
        rb_word_reg <= {shift_reg[OP_MSB:ADDR_LSB], 6'h00, wiper_reg[sel]};
      end
    end
  end

  // Long operation timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      busy_cnt_reg <= '0;
      busy_age_reg <= '0;
    end else if (long_start) begin
      state_reg    <= ST_BUSY;                                         // [RULE16]
      busy_cnt_reg <= BUSY_BITS'(LONG_OP_CYCLES - 1);
      busy_age_reg <= '0;
    end else begin
      case (state_reg)
        ST_BUSY: begin
          busy_age_reg <= busy_age_reg + 11'h001;
          if (busy_cnt_reg == '0) begin
            state_reg <= ST_IDLE;                                      // [RULE4]
          end else begin
            busy_cnt_reg <= busy_cnt_reg - 11'h001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign ready      = 1'b0;
  assign ready_oe_n = (state_reg == ST_IDLE);                          // [RULE4]

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ready_busy;
    long_start |=> !ready_oe_n [*8];
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("ready released too early"); // [RULE16]
  property p_ready_done;
    $fell(state_reg == ST_BUSY) |-> ready_oe_n && busy_age_reg == LONG_OP_CYCLES;
  endproperty
  a_ready_done: assert property (p_ready_done) else $error("ready not back on time"); // [RULE4]

  property p_protect_write;
    exec && protect && op == OP_WIPER_WRITE && !pr_rise |=> $stable(wiper1_setting)
      && $stable(wiper2_setting);
  endproperty
  a_protect_write: assert property (p_protect_write) else $error("protected wiper changed"); // [RULE5]

  property p_protect_nv;
    exec && protect |=> nv_reg[addr] == $past(nv_reg[addr]);
  endproperty
  a_protect_nv: assert property (p_protect_nv) else $error("protected store changed"); // [RULE5]

  property p_preset;
    pr_rise |=> wiper1_setting == $past(nv_reg[0][9:0]) && wiper2_setting == $past(nv_reg[1][9:0])
      && !ready_oe_n;
  endproperty
  a_preset: assert property (p_preset) else $error("preset reload wrong"); // [RULE8]

  property p_preset_edge;
    $fell(pr_sync_reg[1]) && !exec |=> $stable(wiper1_setting) && $stable(wiper2_setting);
  endproperty
  a_preset_edge: assert property (p_preset_edge) else $error("preset acted on fall"); // [RULE9]
  property p_recall_all;
    exec && op == OP_RECALL_ALL && protect |=> wiper1_setting == $past(nv_reg[0][9:0])
      && wiper2_setting == $past(nv_reg[1][9:0]);
  endproperty
  a_recall_all: assert property (p_recall_all) else $error("recall all failed"); // [RULE6]

  property p_write_chan;
    exec && !pr_rise && !protect && op == OP_WIPER_WRITE && !sel
      |=> wiper1_setting == $past(shift_reg[9:0]) && $stable(wiper2_setting);
  endproperty
  a_write_chan: assert property (p_write_chan) else $error("channel write wrong"); // [RULE11]

  property p_shift_msb;
    @(posedge serial_clk) disable iff (!rst_n)
      !cs_n |=> shift_reg[0] == $past(serial_in) && shift_reg[1] == $past(shift_reg[0]);
  endproperty
  a_shift_msb: assert property (p_shift_msb) else $error("shift order wrong"); // [RULE2]

  property p_daisy;
    @(posedge serial_clk) disable iff (!rst_n)
      !cs_n && !rb_mode_reg |=> out_reg == $past(shift_reg[WORD_BITS-1]);
  endproperty
  a_daisy: assert property (p_daisy) else $error("daisy chain delay wrong"); // [RULE13]

  c_preset:   cover property (pr_rise);
  c_nv_write: cover property (exec && op == OP_NV_WRITE && !protect);
  c_readback: cover property (exec && op == OP_WIPER_READ ##1 rb_mode_reg);
  c_blocked:  cover property (exec && protect && op == OP_INC1);
endmodule : rheostat_serial_control
